//--- hdl/ulf_line_format.v
// line format and line signal control with serial framer, infrared path and Avalon-MM slave
//
// Added by the designer: the register offsets and the Avalon-MM register port.
`timescale 1ns/10ps
`default_nettype none
`include "ulf_regs.vh"

module ulf_line_format #(
	parameter [7:0] HALF_TICKS = `ULF_HALF_TICKS,
	parameter [7:0] IR_PULSE   = `ULF_IR_PULSE
) (
	// clock, reset, enable
	input  wire        CLK,
	input  wire        RESET,
	input  wire        CE,
	// Avalon-MM slave
	input  wire [4:0]  ADDRESS,
	input  wire        READ,
	input  wire        WRITE,
	input  wire [31:0] WRITEDATA,
	input  wire [3:0]  BYTEENABLE,
	output wire [31:0] READDATA,
	output wire        WAITREQUEST,
	// serial pins
	input  wire        RX,
	output wire        TX,
	input  wire        IR_RX,
	output wire        IR_TX,
	// divisor latch and enhanced feature access
	output wire        DIV_ACCESS,
	output wire        ENH_ACCESS,
	output wire        DIV_WR,
	output wire        DIV_SEL_HI,
	output wire [7:0]  DIV_WDATA,
	input  wire [15:0] DIV_RDATA
);

	localparam TX_IDLE  = 2'h0;
	localparam TX_SHIFT = 2'h1;
	localparam TX_STOP  = 2'h2;
	localparam RX_IDLE  = 2'h0;
	localparam RX_START = 2'h1;
	localparam RX_BITS  = 2'h2;

	localparam [7:0] HALF_LAST = HALF_TICKS - 8'h01;
	localparam [7:0] BIT_T     = {HALF_TICKS[6:0], 1'b0};
	localparam [7:0] BIT_LAST  = BIT_T - 8'h01;

	reg  [7:0]  fmt_reg;
	reg         presc_reg;
	reg         ir_en_reg;
	reg  [1:0]  pre_cnt_reg;
	reg         wait_reg;
	reg  [7:0]  rdata_reg;
	reg  [7:0]  rd_next;
	reg         div_wr_reg;
	reg         div_hi_reg;
	reg  [7:0]  div_wdata_reg;
	reg         rx_s1_reg;
	reg         rx_s2_reg;
	reg         irrx_s1_reg;
	reg         irrx_s2_reg;
	reg         irrx_d_reg;
	reg  [7:0]  ir_hold_reg;
	reg  [1:0]  tx_st_reg;
	reg  [7:0]  tx_hc_reg;
	reg         tx_ph_reg;
	reg  [9:0]  tx_sh_reg;
	reg  [3:0]  tx_left_reg;
	reg  [2:0]  tx_stop_reg;
	reg         tx_line_reg;
	reg         tx_pin_reg;
	reg         ir_tx_reg;
	reg  [9:0]  tx_frame;
	reg  [2:0]  stop_halves;
	reg  [1:0]  rx_st_reg;
	reg  [7:0]  rx_cnt_reg;
	reg  [3:0]  rx_idx_reg;
	reg  [9:0]  rx_sh_reg;
	reg  [7:0]  rx_data_reg;
	reg         rx_rdy_reg;
	reg         perr_reg;
	reg         ferr_reg;

	// format field decode
	wire        div_acc  = fmt_reg[`ULF_FMT_DIV];
	wire        brk      = fmt_reg[`ULF_FMT_BRK];
	wire [2:0]  par_sel  = fmt_reg[`ULF_FMT_PAR_HI:`ULF_FMT_PAR_LO];
	wire        par_en   = par_sel[0];
	wire        stop_set = fmt_reg[`ULF_FMT_STOP];
	wire [1:0]  len_code = fmt_reg[`ULF_FMT_LEN_HI:`ULF_FMT_LEN_LO];
	wire [3:0]  nbits    = {2'h0, len_code} + 4'h5;
	wire [3:0]  rx_last  = nbits + {3'h0, par_en};

	function [7:0] len_mask;
		input [1:0] lc;
		begin
			case (lc)
				2'h0:    len_mask = 8'h1F;
				2'h1:    len_mask = 8'h3F;
				2'h2:    len_mask = 8'h7F;
				default: len_mask = 8'hFF;
			endcase
		end
	endfunction

	function par_calc;
		input [2:0] sel;
		input [7:0] d;
		input [1:0] lc;
		reg x;
		begin
			x = ^(d & len_mask(lc));
			case (sel)
				3'h3:    par_calc = x;
				3'h5:    par_calc = 1'b1;
				3'h7:    par_calc = 1'b0;
				default: par_calc = ~x;
			endcase
		end
	endfunction

	// bus handshake: one wait state, effects only at the accepting edge
	wire req    = READ | WRITE;
	wire acc_rd = READ & ~wait_reg;
	wire acc_wr = WRITE & ~wait_reg & BYTEENABLE[0];
	wire wr_fmt = acc_wr & (ADDRESS == `ULF_OFS_FORMAT);
	wire wr_sig = acc_wr & (ADDRESS == `ULF_OFS_SIGNAL);
	wire wr_dat = acc_wr & (ADDRESS == `ULF_OFS_DATA);
	wire wr_dhi = acc_wr & (ADDRESS == `ULF_OFS_DIVHI);
	wire rd_dat = acc_rd & (ADDRESS == `ULF_OFS_DATA) & ~div_acc;
	wire rd_st  = acc_rd & (ADDRESS == `ULF_OFS_STATUS);
	wire tx_busy  = (tx_st_reg != TX_IDLE);
	wire tx_start = wr_dat & ~div_acc & ~tx_busy;

	always @* begin
		case (ADDRESS)
			`ULF_OFS_DATA:   rd_next = div_acc ? DIV_RDATA[7:0] : rx_data_reg;
			`ULF_OFS_FORMAT: rd_next = fmt_reg;
			`ULF_OFS_SIGNAL: rd_next = {presc_reg, ir_en_reg, 6'h00};
			`ULF_OFS_STATUS: rd_next = {4'h0, ferr_reg, perr_reg, rx_rdy_reg, tx_busy};
			`ULF_OFS_DIVHI:  rd_next = div_acc ? DIV_RDATA[15:8] : 8'h00;
			default:         rd_next = 8'h00;
		endcase
	end

	always @(posedge CLK) begin
		if (RESET) begin
			wait_reg  <= 1'b1;
			rdata_reg <= 8'h00;
		end else if (CE) begin
			if (req & wait_reg) begin
				wait_reg  <= 1'b0;
				rdata_reg <= rd_next;
			end else begin
				wait_reg <= 1'b1;
			end
		end
	end

	// control registers
	always @(posedge CLK) begin
		if (RESET) begin
			fmt_reg   <= `ULF_FMT_RESET;
			presc_reg <= `ULF_SIG_RESET;
			ir_en_reg <= `ULF_SIG_RESET;
		end else if (CE) begin
			if (wr_fmt)
				fmt_reg <= WRITEDATA[7:0];
			if (wr_sig) begin
				presc_reg <= WRITEDATA[`ULF_SIG_PRESC];
				ir_en_reg <= WRITEDATA[`ULF_SIG_IR];
			end
		end
	end

	// divisor latch strobes go out, the latch itself lives elsewhere
	always @(posedge CLK) begin
		if (RESET) begin
			div_wr_reg    <= 1'b0;
			div_hi_reg    <= 1'b0;
			div_wdata_reg <= 8'h00;
		end else if (CE) begin
			div_wr_reg <= div_acc & (wr_dat | wr_dhi);
			if (div_acc & (wr_dat | wr_dhi)) begin
				div_hi_reg    <= wr_dhi;
				div_wdata_reg <= WRITEDATA[7:0];
			end
		end
	end

	// prescaler: divide-by-1 ticks every cycle
	wire tick = ~presc_reg | (pre_cnt_reg == `ULF_PRESC_MAX);

	always @(posedge CLK) begin
		if (RESET)
			pre_cnt_reg <= 2'h0;
		else if (CE)
			pre_cnt_reg <= pre_cnt_reg + 2'h1;
	end

	// pin synchronisers and infrared pulse stretcher
	always @(posedge CLK) begin
		if (RESET) begin
			rx_s1_reg   <= 1'b1;
			rx_s2_reg   <= 1'b1;
			irrx_s1_reg <= 1'b0;
			irrx_s2_reg <= 1'b0;
			irrx_d_reg  <= 1'b0;
			ir_hold_reg <= 8'h00;
		end else if (CE) begin
			rx_s1_reg   <= RX;
			rx_s2_reg   <= rx_s1_reg;
			irrx_s1_reg <= IR_RX;
			irrx_s2_reg <= irrx_s1_reg;
			irrx_d_reg  <= irrx_s2_reg;
			// a short light pulse means a zero bit; stretch it over one bit time
			if (irrx_s2_reg & ~irrx_d_reg)
				ir_hold_reg <= BIT_T;
			else if (tick && ir_hold_reg != 8'h00)
				ir_hold_reg <= ir_hold_reg - 8'h01;
		end
	end

	wire rx_line = ir_en_reg ? (ir_hold_reg == 8'h00) : rx_s2_reg;

	// transmit frame: data, parity, then ones above
	always @* begin
		tx_frame = {2'h3, WRITEDATA[7:0] | ~len_mask(len_code)};
		if (par_en)
			tx_frame[nbits] = par_calc(par_sel, WRITEDATA[7:0], len_code);
	end

	always @* begin
		if (!stop_set)
			stop_halves = `ULF_STOP_ONE;
		else if (len_code == 2'h0)
			stop_halves = `ULF_STOP_HALF3;
		else
			stop_halves = `ULF_STOP_TWO;
	end

	wire tx_half = tick && (tx_hc_reg == HALF_LAST);

	// half-bit timer runs free when idle so a break still pulses the infrared output
	always @(posedge CLK) begin
		if (RESET) begin
			tx_st_reg   <= TX_IDLE;
			tx_hc_reg   <= 8'h00;
			tx_ph_reg   <= 1'b0;
			tx_sh_reg   <= 10'h3FF;
			tx_left_reg <= 4'h0;
			tx_stop_reg <= 3'h0;
			tx_line_reg <= 1'b1;
		end else if (CE) begin
			if (tx_start) begin
				tx_st_reg   <= TX_SHIFT;
				tx_hc_reg   <= 8'h00;
				tx_ph_reg   <= 1'b0;
				tx_sh_reg   <= tx_frame;
				tx_left_reg <= rx_last;
				tx_line_reg <= 1'b0;
			end else begin
				if (tick)
					tx_hc_reg <= tx_half ? 8'h00 : tx_hc_reg + 8'h01;
				if (tx_half)
					tx_ph_reg <= ~tx_ph_reg;
				case (tx_st_reg)
					TX_SHIFT: begin
						if (tx_half & tx_ph_reg) begin
							if (tx_left_reg == 4'h0) begin
								tx_st_reg   <= TX_STOP;
								tx_stop_reg <= stop_halves;
								tx_line_reg <= 1'b1;
							end else begin
								tx_line_reg <= tx_sh_reg[0];
								tx_sh_reg   <= {1'b1, tx_sh_reg[9:1]};
								tx_left_reg <= tx_left_reg - 4'h1;
							end
						end
					end
					TX_STOP: begin
						if (tx_half) begin
							if (tx_stop_reg == 3'h1)
								tx_st_reg <= TX_IDLE;
							else
								tx_stop_reg <= tx_stop_reg - 3'h1;
						end
					end
					TX_IDLE: begin
						tx_line_reg <= 1'b1;
					end
					default: begin
						tx_st_reg <= TX_IDLE;
					end
				endcase
			end
		end
	end

	// pin stage: break overrides the framer, infrared keeps the wired pin idle
	wire ser_line = brk ? 1'b0 : tx_line_reg;

	always @(posedge CLK) begin
		if (RESET) begin
			tx_pin_reg <= 1'b1;
			ir_tx_reg  <= 1'b0;
		end else if (CE) begin
			tx_pin_reg <= ir_en_reg ? 1'b1 : ser_line;
			ir_tx_reg  <= ir_en_reg & ~ser_line & ~tx_ph_reg & (tx_hc_reg < IR_PULSE);
		end
	end

	// receiver: start bit checked at its middle, then one sample per bit
	wire rx_par_bad = par_en & (rx_sh_reg[nbits] != par_calc(par_sel, rx_sh_reg[7:0], len_code));

	always @(posedge CLK) begin
		if (RESET) begin
			rx_st_reg   <= RX_IDLE;
			rx_cnt_reg  <= 8'h00;
			rx_idx_reg  <= 4'h0;
			rx_sh_reg   <= 10'h000;
			rx_data_reg <= 8'h00;
			rx_rdy_reg  <= 1'b0;
			perr_reg    <= 1'b0;
			ferr_reg    <= 1'b0;
		end else if (CE) begin
			// clears first so a same-cycle set wins
			if (rd_dat)
				rx_rdy_reg <= 1'b0;
			if (rd_st) begin
				perr_reg <= 1'b0;
				ferr_reg <= 1'b0;
			end
			case (rx_st_reg)
				RX_IDLE: begin
					if (!rx_line) begin
						rx_st_reg  <= RX_START;
						rx_cnt_reg <= 8'h00;
					end
				end
				RX_START: begin
					if (tick) begin
						if (rx_cnt_reg == HALF_LAST) begin
							rx_st_reg  <= rx_line ? RX_IDLE : RX_BITS;
							rx_cnt_reg <= 8'h00;
							rx_idx_reg <= 4'h0;
							rx_sh_reg  <= 10'h000;
						end else begin
							rx_cnt_reg <= rx_cnt_reg + 8'h01;
						end
					end
				end
				RX_BITS: begin
					if (tick) begin
						if (rx_cnt_reg == BIT_LAST) begin
							rx_cnt_reg <= 8'h00;
							if (rx_idx_reg == rx_last) begin
								// only the first stop bit is checked
								rx_st_reg   <= RX_IDLE;
								rx_data_reg <= rx_sh_reg[7:0] & len_mask(len_code);
								rx_rdy_reg  <= 1'b1;
								if (rx_par_bad)
									perr_reg <= 1'b1;
								if (!rx_line)
									ferr_reg <= 1'b1;
							end else begin
								rx_sh_reg[rx_idx_reg] <= rx_line;
								rx_idx_reg <= rx_idx_reg + 4'h1;
							end
						end else begin
							rx_cnt_reg <= rx_cnt_reg + 8'h01;
						end
					end
				end
				default: begin
					rx_st_reg <= RX_IDLE;
				end
			endcase
		end
	end

	assign READDATA    = {24'h000000, rdata_reg};
	assign WAITREQUEST = wait_reg;
	assign TX          = tx_pin_reg;
	assign IR_TX       = ir_tx_reg;
	assign DIV_ACCESS  = fmt_reg[`ULF_FMT_DIV];
	assign ENH_ACCESS  = fmt_reg[`ULF_FMT_DIV];
	assign DIV_WR      = div_wr_reg;
	assign DIV_SEL_HI  = div_hi_reg;
	assign DIV_WDATA   = div_wdata_reg;

endmodule

`default_nettype wire

//--- hdl/ulf_regs.vh
// register offsets, field positions, reset values and timing defaults of the line format block
// Functional notes
// - format top bit maps accesses onto divisor
// - same bit grants enhanced feature access
// - break bit holds transmit line low in wired mode, pulses infrared output each bit otherwise
// - parity: none, odd 001, even 011, zero 111
// - stop: one; set gives 1.5 or two
// - length code 00..11 selects 5..8 bits
// - reset clears format: five bits, one stop
// - signal bit 7 divides input clock by four
// - signal bit 6 selects infrared path
// - infrared carries serial data, idles output low
`ifndef ULF_REGS_VH
`define ULF_REGS_VH

`define ULF_OFS_DATA    5'h00
`define ULF_OFS_FORMAT  5'h04
`define ULF_OFS_SIGNAL  5'h08
`define ULF_OFS_STATUS  5'h0C
`define ULF_OFS_DIVHI   5'h10

`define ULF_FMT_DIV     7
`define ULF_FMT_BRK     6
`define ULF_FMT_PAR_HI  5
`define ULF_FMT_PAR_LO  3
`define ULF_FMT_STOP    2
`define ULF_FMT_LEN_HI  1
`define ULF_FMT_LEN_LO  0
`define ULF_SIG_PRESC   7
`define ULF_SIG_IR      6
`define ULF_ST_BUSY     0
`define ULF_ST_RXRDY    1
`define ULF_ST_PERR     2
`define ULF_ST_FERR     3

`define ULF_FMT_RESET   8'h00
`define ULF_SIG_RESET   1'h0

`define ULF_PRESC_MAX   2'h3
`define ULF_HALF_TICKS  8'h08
`define ULF_IR_PULSE    8'h03
`define ULF_STOP_ONE    3'h2
`define ULF_STOP_HALF3  3'h3
`define ULF_STOP_TWO    3'h4

`endif

//--- tb/test_uart_line_format_control.sv
// self-checking bench for the line format block
`timescale 1ns/10ps
`default_nettype none
module test_uart_line_format_control;
	localparam int BT = 8;
	logic        clk, reset, read, write, tx, ir_tx, rx, ir_rx;
	logic        div_access, enh_access, div_wr, div_sel_hi, waitrequest;
	logic [4:0]  address;
	logic [31:0] writedata, readdata;
	logic [7:0]  div_wdata, d;
	logic [8:0]  div_seen;
	logic [11:0] got, exp;
	logic        ir_q;
	int          mismatches, cmp_count, pulses, n;
	logic [7:0]  fmts [6] = '{8'h00, 8'h01, 8'h0A, 8'h1B, 8'h2C, 8'h3F};

	ulf_line_format #(.HALF_TICKS(8'h04), .IR_PULSE(8'h02)) DUT (
		.CLK(clk), .RESET(reset), .CE(1'b1), .ADDRESS(address), .READ(read), .WRITE(write),
		.WRITEDATA(writedata), .BYTEENABLE(4'h1), .READDATA(readdata), .WAITREQUEST(waitrequest),
		.RX(rx), .TX(tx), .IR_RX(ir_rx), .IR_TX(ir_tx), .DIV_ACCESS(div_access), .ENH_ACCESS(enh_access),
		.DIV_WR(div_wr), .DIV_SEL_HI(div_sel_hi), .DIV_WDATA(div_wdata), .DIV_RDATA(16'hC3A5));
	ulf_remote rem (.CLK(clk), .TX(tx), .RX(rx), .IR_RX(ir_rx));

	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		ir_q <= ir_tx;
		if (div_wr === 1'b1)
			div_seen <= {div_sel_hi, div_wdata};
		if (ir_tx === 1'b1 && ir_q === 1'b0)
			pulses++;
	end

	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("unexpected at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic wr, input logic [4:0] a, input logic [7:0] v);
		@(posedge clk);
		address <= a;
		writedata <= {24'h000000, v};
		read <= !wr;
		write <= wr;
		do @(posedge clk); while (waitrequest !== 1'b0);
		read <= 1'b0;
		write <= 1'b0;
	endtask
	task automatic rdc(input logic [4:0] a, input logic [7:0] e);
		bus(1'b0, a, 8'h00);
		chk(readdata, {24'h000000, e});
	endtask
	// expected line bits: start, data lsb first, parity, marks after
	function automatic logic [11:0] frame(input logic [7:0] v, input logic [7:0] f, output int m);
		int  nb;
		logic p;
		nb = 5 + f[1:0];
		frame = 12'hFFF;
		frame[0] = 1'b0;
		for (int i = 0; i < nb; i++) frame[i + 1] = v[i];
		p = ^(v & ~(8'hFF << nb));
		m = nb + ((f[2] && nb > 5) ? 3 : 2);
		if (f[3]) begin
			frame[nb + 1] = f[5] ? !f[4] : (f[4] ? p : !p);
			m++;
		end
	endfunction
	task automatic report_and_stop();
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge clk);
		mismatches++;
		report_and_stop();
	end
	initial begin
		reset = 1'b1;
		read = 1'b0;
		write = 1'b0;
		address = 5'h00;
		writedata = 32'h00000000;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		rdc(5'h04, 8'h00);
		rdc(5'h08, 8'h00);
		chk({ir_tx, tx}, 2'h1);
		rdc(5'h14, 8'h00);
		foreach (fmts[k]) begin
			d = 8'h96 + 8'(k);
			bus(1'b1, 5'h04, fmts[k]);
			rdc(5'h04, fmts[k]);
			exp = frame(d, fmts[k], n);
			bus(1'b1, 5'h00, d);
			rem.grab(n, BT, got);
			chk(got, exp);
			repeat (4 * BT) @(posedge clk);
		end
		bus(1'b1, 5'h04, 8'h43);
		repeat (3) @(posedge clk);
		chk(tx, 1'b0);
		repeat (20 * BT) @(posedge clk);
		chk(tx, 1'b0);
		bus(1'b1, 5'h04, 8'h83);
		// the write lands at the accepting edge, so look one edge later
		@(posedge clk);
		chk({div_access, enh_access}, 2'h3);
		bus(1'b1, 5'h10, 8'h5A);
		repeat (2) @(posedge clk);
		chk(div_seen, 9'h15A);
		rdc(5'h10, 8'hC3);
		rdc(5'h00, 8'hA5);
		bus(1'b1, 5'h04, 8'h03);
		@(posedge clk);
		chk({div_access, enh_access, tx}, 3'h1);
		rdc(5'h10, 8'h00);
		bus(1'b1, 5'h08, 8'h80);
		rdc(5'h08, 8'h80);
		exp = frame(8'h3C, 8'h03, n);
		bus(1'b1, 5'h00, 8'h3C);
		rem.grab(n, 4 * BT, got);
		chk(got, exp);
		repeat (16 * BT) @(posedge clk);
		bus(1'b1, 5'h08, 8'h40);
		rdc(5'h08, 8'h40);
		pulses = 0;
		bus(1'b1, 5'h00, 8'h0F);
		repeat (12 * BT) @(posedge clk);
		chk(pulses, 5);
		chk({ir_tx, tx}, 2'h1);
		// infrared receive: one light pulse per zero bit
		exp = frame(8'h5A, 8'h03, n);
		rem.send_ir(exp, n, BT);
		repeat (2 * BT) @(posedge clk);
		rdc(5'h0C, 8'h02);
		rdc(5'h00, 8'h5A);
		bus(1'b1, 5'h08, 8'h00);
		exp = frame(8'h69, 8'h03, n);
		rem.send(exp, n, BT);
		rdc(5'h0C, 8'h02);
		rdc(5'h00, 8'h69);
		report_and_stop();
	end
endmodule

bind ulf_line_format ulf_line_format_sva CHK (
	.CLK(CLK), .RESET(RESET), .CE(CE), .ADDRESS(ADDRESS), .READ(READ), .WRITE(WRITE),
	.WRITEDATA(WRITEDATA), .BYTEENABLE(BYTEENABLE), .WAITREQUEST(WAITREQUEST), .TX(TX),
	.IR_TX(IR_TX), .DIV_ACCESS(DIV_ACCESS), .ENH_ACCESS(ENH_ACCESS), .DIV_WR(DIV_WR));
`default_nettype wire

//--- tb/ulf_line_format_sva.sv
// port-level assertions for the line format block
`timescale 1ns/10ps
`default_nettype none
module ulf_line_format_sva (
	// clock, reset and enable
	input wire logic        CLK,
	input wire logic        RESET,
	input wire logic        CE,
	// register bus
	input wire logic [4:0]  ADDRESS,
	input wire logic        READ,
	input wire logic        WRITE,
	input wire logic [31:0] WRITEDATA,
	input wire logic [3:0]  BYTEENABLE,
	input wire logic        WAITREQUEST,
	// line and access outputs
	input wire logic        TX,
	input wire logic        IR_TX,
	input wire logic        DIV_ACCESS,
	input wire logic        ENH_ACCESS,
	input wire logic        DIV_WR
);
	logic [7:0] fmt_reg;
	logic       ir_reg;
	wire        wr_ok = WRITE && !WAITREQUEST && BYTEENABLE[0] && CE;
	default clocking @(posedge CLK); endclocking
	default disable iff (RESET);
	// shadow copies, so line effects can be tied to the write that caused them
	always @(posedge CLK) begin
		if (RESET) begin
			fmt_reg <= 8'h00;
			ir_reg <= 1'b0;
		end else if (wr_ok && ADDRESS == 5'h04) begin
			fmt_reg <= WRITEDATA[7:0];
		end else if (wr_ok && ADDRESS == 5'h08) begin
			ir_reg <= WRITEDATA[6];
		end
	end
	a_wait_answer:
		assert property ((READ || WRITE) && WAITREQUEST && CE |=> !WAITREQUEST) else $error("late answer");
	a_wait_single:
		assert property (!WAITREQUEST |=> WAITREQUEST) else $error("long answer");
	a_div_follow:
		assert property (wr_ok && ADDRESS == 5'h04 |=> DIV_ACCESS == $past(WRITEDATA[7])) else $error("access bit");
	a_enh_same:
		assert property (ENH_ACCESS == DIV_ACCESS) else $error("enhanced access");
	a_reset_clear:
		assert property ($fell(RESET) |-> !DIV_ACCESS && TX && !IR_TX) else $error("reset state");
	a_break_low:
		assert property (fmt_reg[6] && !ir_reg ##2 fmt_reg[6] && !ir_reg |-> !TX) else $error("break line");
	a_ir_high:
		assert property (ir_reg ##2 ir_reg |-> TX) else $error("serial pin in infrared mode");
	a_div_pulse:
		assert property (DIV_WR |-> DIV_ACCESS ##1 !DIV_WR) else $error("divisor strobe");
	cover property (wr_ok && ADDRESS == 5'h04 && WRITEDATA[7]);
	cover property (fmt_reg[6] && !TX);
	cover property ($rose(IR_TX));
endmodule
`default_nettype wire

//--- tb/ulf_remote.sv
// remote serial station: drives the receive lines, samples the transmit line
`timescale 1ns/10ps
`default_nettype none
module ulf_remote (
	// clock
	input  wire logic CLK,
	// serial lines
	input  wire logic TX,
	output var  logic RX,
	output var  logic IR_RX
);
	initial begin
		RX = 1'b1;
		IR_RX = 1'b0;
	end
	// bits go out lsb first, bt cycles each; line returns to mark
	task automatic send(input logic [11:0] f, input int n, input int bt);
		for (int i = 0; i < n * bt; i++) begin
			@(posedge CLK);
			RX <= f[i / bt];
		end
		@(posedge CLK);
		RX <= 1'b1;
	endtask
	// infrared: a one-cycle light pulse at the start of each zero bit
	task automatic send_ir(input logic [11:0] f, input int n, input int bt);
		for (int i = 0; i < n; i++) begin
			@(posedge CLK);
			IR_RX <= !f[i];
			@(posedge CLK);
			IR_RX <= 1'b0;
			repeat (bt - 2) @(posedge CLK);
		end
	endtask
	// middle-of-bit sampling after the start edge
	task automatic grab(input int n, input int bt, output logic [11:0] f);
		int w;
		f = 12'hFFF;
		w = 0;
		while (TX !== 1'b0 && w < 4000) begin
			@(posedge CLK);
			w++;
		end
		repeat (bt / 2) @(posedge CLK);
		for (int i = 0; i < n; i++) begin
			f[i] = TX;
			repeat (bt) @(posedge CLK);
		end
	endtask
endmodule
`default_nettype wire
